// >>> dsm_master.sv
// Fieldbus parameter-access master model
`timescale 1ns/10ps
module dsm_master (
  input  wire        clk_i,
  output reg  [15:0] addr_o,
  output reg         wr_o,
  output reg         rd_o,
  output reg  [15:0] wdata_o,
  input  wire [15:0] rdata_i,
  input  wire        ack_i,
  input  wire        err_i
);
  initial {addr_o, wr_o, rd_o, wdata_o} = 34'h0;
  // One-cycle strobe; the answer is read at the next falling edge
  task acc(input w, input [15:0] a, d, output [15:0] q, output e);
    begin
      @(negedge clk_i);
      {addr_o, wr_o, rd_o, wdata_o} = {a, w, !w, d};
      @(negedge clk_i);
      // Ack from the taking edge stands here; missing ack spoils both
      q = ack_i ? rdata_i : ~rdata_i;
      e = ack_i ? err_i : !err_i;
      // Idle lines show inverted values so stale data cannot pass
      {addr_o, wr_o, rd_o, wdata_o} = {~a, 2'h0, ~d};
    end
  endtask
endmodule

// >>> dsm_regs.vh
// Register offsets, field positions and reset values of the monitor bank
`ifndef DSM_REGS_VH
`define DSM_REGS_VH
`define DSM_ADDR_TRACK_CLASS 16'h0516
`define DSM_ADDR_ACTION      16'h1c08
`define DSM_ADDR_STOP_ERR    16'h1c0a
`define DSM_ADDR_SAVED_WARN  16'h1c18
`define DSM_RST_TRACK_CLASS  16'h0003
`define DSM_RST_CLASS_OUT    2'h3
`define DSM_RST_ZERO         16'h0000
`define DSM_CLASS_MIN        16'h0001
`define DSM_CLASS_MAX        16'h0003
`define DSM_WARN_VALID_MASK  16'h7ff7
`define DSM_WARN_AUTO_MASK   16'h2c00
`define DSM_ACT_WARN         0
`define DSM_ACT_CLASS1       1
`define DSM_ACT_CLASS4       4
`define DSM_ACT_STANDSTILL   6
`define DSM_ACT_CW           7
`define DSM_ACT_CCW          8
`define DSM_ACT_PG_IDLE      11
`define DSM_ACT_PG_CONST     14
`define DSM_STANDSTILL_RPM   16'h0009
`endif

// >>> dsm_top.v
// Drive status monitor register bank: warnings, action word, fault class
//
// Behaviour
// - Saved warnings stick until fault clear
// - Bits 10, 11, 13 self-clear when gone
// - Saved warning word read-only, resets zero
// - Bits 0,1,2,4,5,6: general, temperatures, overloads
// - Bits 7,8,9,12,14: bus and encoder warnings
// - Bit 10 torque off, 11 undervoltage, 13 position
// - Action bits 0-4: warning, classes 1-4
// - Action bits 6-8: standstill, rotation direction
// - Action bits 11-14: profile generator phase
// - Last stop error number, read-only, zero
// - Tracking class 1..3, default 3, reject others
`timescale 1ns/10ps
`include "dsm_regs.vh"

// Register map, every word 16 bits wide:
//   tracking error class select  read/write, accepts 1..3 only
//   action word                  read-only, live drive status
//   last stop error number       read-only, latched on an event
//   saved warning word           read-only, sticky warning flags
//
// Access timing: a read or write strobe taken on a rising edge is
// answered one cycle later by an ack pulse with err beside it.
// Read data is registered and holds until the next read, so a
// slow master may pick it up late. Strobes may come every cycle.
//
// A read and a write strobed together count as a read only; the
// write is dropped rather than half applied.
//
// The action word read back is the registered copy, so it lags the
// live inputs by one cycle; read data holds the port value from before the taking edge, so the port may have moved on.
//
// Direction bits stay low inside the standstill band, so exactly
// one of standstill, clockwise and counter-clockwise is ever set.
//
// Warning inputs are live levels; the sticky word catches a warning
// that lasts a single cycle on any bit but 3, 10, 11, 13, 15, which a polling master would miss.
//
// Limitation: no ordering is kept between warnings; the word shows
// which occurred, not which came first.

module dsm_top #(
  parameter AW = 16                        // Parameter address width
) (
  input  wire          clk_sys_i,          // System clock, 10 MHz
  input  wire          rst_i,              // Async reset, active high
  // Parameter access port
  input  wire [AW-1:0] par_addr_i,         // Parameter address
  input  wire          par_wr_i,           // Write strobe
  input  wire          par_rd_i,           // Read strobe
  input  wire [15:0]   par_wdata_i,        // Write data
  output reg  [15:0]   par_rdata_o,        // Read data, registered
  output reg           par_ack_o,          // Access done pulse
  output reg           par_err_o,          // Rejected or unmapped
  // Monitor inputs
  input  wire [15:0]   warn_active_i,      // Live warning conditions
  input  wire          fault_clear_command_i, // Fault clear pulse
  input  wire [3:0]    err_class_active_i, // Other active classes 1..4
  input  wire [15:0]   speed_rpm_i,        // Signed actual speed
  input  wire [1:0]    pg_phase_i,         // 0 idle 1 dec 2 acc 3 const
  input  wire          stop_fault_i,       // Stop fault event pulse
  input  wire [15:0]   stop_fault_num_i,   // Its error number
  input  wire          track_err_i,        // Tracking error event pulse
  input  wire [15:0]   track_err_num_i,    // Tracking error number
  // Status outputs
  output reg  [1:0]    track_class_o,      // Configured class 1..3
  output reg  [15:0]   action_word_o       // Action word mirror
);

  reg  [15:0] saved_warning_word_q;        // Sticky warnings
  reg  [15:0] saved_warning_word_d;        // Next sticky word
  reg  [15:0] last_stop_error_number_q;    // Last stop fault number
  reg  [15:0] track_class_q;               // Tracking error class
  reg  [3:0]  track_class_hold_q;          // Tracking class flags held
  reg  [15:0] action_d;                    // Next action word
  reg  [15:0] speed_mag;                   // Speed magnitude
  wire        class_ok;                    // Write value in range
  wire        wr_class;                    // Write to class register
  wire [3:0]  track_class_bit;             // One-hot flag of the class

  assign class_ok = (par_wdata_i >= `DSM_CLASS_MIN) &&
                    (par_wdata_i <= `DSM_CLASS_MAX);
  // A read strobed in the same cycle wins, so the write is dropped
  assign wr_class = par_wr_i && !par_rd_i &&
                    (par_addr_i == `DSM_ADDR_TRACK_CLASS);
  // Class 1..3 maps to bit 0..2 of the held flags
  assign track_class_bit = 4'h1 << (track_class_q[1:0] - 2'h1);

  // Sticky warning update; a new warning beats a same-cycle clear
  always @* begin
    saved_warning_word_d = saved_warning_word_q;
    if (fault_clear_command_i) begin
      saved_warning_word_d = `DSM_RST_ZERO;
    end
    // Auto bits follow their live condition
    // so they drop the cycle after the condition goes
    saved_warning_word_d = (saved_warning_word_d &
                            ~`DSM_WARN_AUTO_MASK) |
                           (saved_warning_word_d &
                            warn_active_i &
                            `DSM_WARN_AUTO_MASK);
    // Set always wins; reserved bits 3, 15 stay zero
    // A warning present during a clear therefore survives it
    saved_warning_word_d = saved_warning_word_d |
      (warn_active_i & `DSM_WARN_VALID_MASK);
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      saved_warning_word_q <= `DSM_RST_ZERO;
    end else begin
      saved_warning_word_q <= saved_warning_word_d;
    end
  end

  // Tracking-error class flag held until fault clear
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      track_class_hold_q <= 4'h0;                        // Nothing held
    end else if (track_err_i) begin
      // Event wins: a same-cycle clear drops only older flags
      if (fault_clear_command_i) begin
        track_class_hold_q <= track_class_bit;
      end else begin
        track_class_hold_q <= track_class_hold_q |
                              track_class_bit;
      end
    end else if (fault_clear_command_i) begin
      track_class_hold_q <= 4'h0;                        // Clear all flags
    end
  end

  // Last stop fault number; tracking error counts as a stop fault
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      last_stop_error_number_q <= `DSM_RST_ZERO;
    end else if (track_err_i) begin
      last_stop_error_number_q <= track_err_num_i;
    // Plain stop fault when no tracking error competes
    end else if (stop_fault_i) begin
      last_stop_error_number_q <= stop_fault_num_i;
    end
  end

  // Class select: out-of-range values leave the old class
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      track_class_q <= `DSM_RST_TRACK_CLASS;
    // Upper bits stay zero since only 1..3 is ever stored
    end else if (wr_class && class_ok) begin
      track_class_q <= par_wdata_i;
    end
  end

  // Action word assembly from live state
  always @* begin
    action_d = `DSM_RST_ZERO;
    // Two's complement magnitude; the sign bit picks direction
    speed_mag = speed_rpm_i[15] ? (~speed_rpm_i + 16'h0001) : speed_rpm_i;
    action_d[`DSM_ACT_WARN] = |warn_active_i;
    action_d[`DSM_ACT_CLASS4:`DSM_ACT_CLASS1] =
      err_class_active_i | track_class_hold_q;
    action_d[`DSM_ACT_STANDSTILL] =
      (speed_mag < `DSM_STANDSTILL_RPM);
    // Direction only outside the standstill band
    action_d[`DSM_ACT_CW]  = !speed_rpm_i[15] &&
                             (speed_mag >= `DSM_STANDSTILL_RPM);
    action_d[`DSM_ACT_CCW] = speed_rpm_i[15] &&
                             (speed_mag >= `DSM_STANDSTILL_RPM);
    // Profile phase decoded one-hot into bits 11..14
    action_d[`DSM_ACT_PG_CONST:`DSM_ACT_PG_IDLE] =
      4'h1 << pg_phase_i;
  end

  // Status ports registered so they come straight from flops
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      action_word_o <= `DSM_RST_ZERO;
      track_class_o <= `DSM_RST_CLASS_OUT;
    end else begin
      action_word_o <= action_d;
      track_class_o <= track_class_q[1:0];
    end
  end

  // Parameter access: one-cycle ack, read-only writes ignored
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      par_rdata_o <= `DSM_RST_ZERO;
      par_ack_o   <= 1'b0;
      par_err_o   <= 1'b0;
    end else begin
      // Every strobe earns exactly one ack pulse
      par_ack_o <= par_rd_i || par_wr_i;
      par_err_o <= 1'b0;
      if (par_rd_i) begin
        // Mapped words return contents; others read zero
        case (par_addr_i)
          `DSM_ADDR_TRACK_CLASS: par_rdata_o <= track_class_q;
          `DSM_ADDR_ACTION:      par_rdata_o <= action_word_o;
          `DSM_ADDR_STOP_ERR:    par_rdata_o <= last_stop_error_number_q;
          `DSM_ADDR_SAVED_WARN:  par_rdata_o <= saved_warning_word_q;
          default: begin
            par_rdata_o <= `DSM_RST_ZERO;
            par_err_o   <= 1'b1;
          end
        endcase
      end else if (par_wr_i) begin
        // Read-only targets keep contents, flagged as error
        if (wr_class) begin
          par_err_o <= !class_ok;
        end else begin
          par_err_o <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> dsm_top_sva.sv
// Port checker of the drive status monitor bank
`timescale 1ns/10ps
module dsm_chk (
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire [15:0] par_addr_i,
  input wire        par_wr_i,
  input wire        par_rd_i,
  input wire [15:0] par_wdata_i,
  input wire        par_err_o,
  input wire [15:0] speed_rpm_i,
  input wire [1:0]  pg_phase_i,
  input wire [1:0]  track_class_o,
  input wire [15:0] action_word_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Class write without a competing read; read wins when both strobe
  wire wr_cls = par_wr_i && !par_rd_i && par_addr_i == 16'h0516;
  wire ok_cls = par_wdata_i inside {[16'h0001:16'h0003]};
  wire signed [15:0] spd = speed_rpm_i;
  ro_write_a: assert property (par_wr_i && !par_rd_i &&
    par_addr_i == 16'h1c18 |=> par_err_o) else $error("RO write not refused");
  class_write_a: assert property (wr_cls && ok_cls |=> !par_err_o
    ##1 {14'h0, track_class_o} == $past(par_wdata_i, 2))
    else $error("bad class");
  class_reject_a: assert property (wr_cls && !ok_cls |=> par_err_o
    ##1 $stable(track_class_o)) else $error("class not rejected");
  class_range_a: assert property (track_class_o != 2'h0)
    else $error("class out of range");
  resv_zero_a: assert property ((action_word_o & 16'h8620) == 16'h0)
    else $error("reserved action bit set");
  pg_phase_a: assert property (1 |=>
    action_word_o[14:11] == 4'h1 << $past(pg_phase_i)) else $error("phase");
  still_a: assert property (spd < 16'sh9 && spd > -16'sh9 |=>
    action_word_o[8:6] == 3'h1) else $error("standstill");
  cw_a: assert property (spd > 16'sh8 |=> action_word_o[8:6] == 3'h2)
    else $error("clockwise");
  ccw_a: assert property (spd < -16'sh8 |=>
    action_word_o[8:6] == 3'h4) else $error("counter-clockwise");
  cover property (wr_cls && ok_cls);
  cover property (par_err_o);
  cover property (action_word_o[1]);
endmodule
bind dsm_top dsm_chk dsm_chk_i (.clk_sys_i, .rst_i, .par_addr_i, .par_wr_i,
  .par_rd_i, .par_wdata_i, .par_err_o, .speed_rpm_i, .pg_phase_i,
  .track_class_o, .action_word_o);

// >>> dsm_top_tb.sv
// Self-checking bench of the drive status monitor bank
`timescale 1ns/10ps
`include "dsm_regs.vh"
module dsm_top_tb;
  reg         clk_sys_i = 1'b0, rst_i = 1'b1, fc = 1'b0, sf = 1'b0, te = 1'b0;
  reg  [15:0] warn = 16'h0, spd = 16'h0, sf_n = 16'h0, te_n = 16'h0, q;
  reg  [3:0]  ecls = 4'h0;
  reg  [1:0]  pg = 2'h0;
  reg         e;
  reg  [38:0] rows [0:4]; // Speed, phase, classes, warning, action
  wire [15:0] addr, wdata, rdata, act;
  wire        wr, rd, ack, err;
  wire [1:0]  cls;
  integer     num_errors = 0, n_tests = 0, cyc = 0, i;
  always #50 clk_sys_i = ~clk_sys_i;
  dsm_top dsm_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .par_addr_i(addr),
    .par_wr_i(wr), .par_rd_i(rd), .par_wdata_i(wdata), .par_rdata_o(rdata),
    .par_ack_o(ack), .par_err_o(err), .warn_active_i(warn),
    .fault_clear_command_i(fc), .err_class_active_i(ecls), .speed_rpm_i(spd),
    .pg_phase_i(pg), .stop_fault_i(sf), .stop_fault_num_i(sf_n),
    .track_err_i(te), .track_err_num_i(te_n), .track_class_o(cls),
    .action_word_o(act));
  dsm_master dsm_master_i (.clk_i(clk_sys_i), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata), .ack_i(ack), .err_i(err));
  task chk(input [8*5:1] nm, input [15:0] ex, got);
    begin
      n_tests = n_tests + 1;
      if (got !== ex) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task rw(input w, input [15:0] a, d, xq, input xe);
    begin
      dsm_master_i.acc(w, a, d, q, e);
      if (!w) chk("rdata", xq, q);
      chk("err", {15'h0, xe}, {15'h0, e});
    end
  endtask
  // Pulse one input for a single cycle
  task fclear;
    begin
      @(negedge clk_sys_i) fc = 1'b1;
      @(negedge clk_sys_i) fc = 1'b0;
      @(negedge clk_sys_i);
    end
  endtask
  task end_sim;
    begin
      if (num_errors == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Run is about 80 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  initial begin
    rows[0] = {16'h0000, 2'h0, 4'h0, 1'b0, 16'h0840};
    rows[1] = {16'h0009, 2'h2, 4'h1, 1'b1, 16'h2083};
    rows[2] = {16'h0008, 2'h1, 4'ha, 1'b0, 16'h1054};
    rows[3] = {16'hfff7, 2'h3, 4'h4, 1'b1, 16'h4109};
    rows[4] = {16'hfff8, 2'h0, 4'h0, 1'b0, 16'h0840};
    repeat (8) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("cls", 16'h3, {14'h0, cls});
    rw(0, `DSM_ADDR_TRACK_CLASS, 0, 16'h3, 0);
    rw(0, `DSM_ADDR_SAVED_WARN, 0, 16'h0, 0);
    rw(0, `DSM_ADDR_STOP_ERR, 0, 16'h0, 0);
    for (i = 0; i < 5; i = i + 1) begin
      @(negedge clk_sys_i) {spd, pg, ecls, warn[0]} = rows[i][38:16];
      @(negedge clk_sys_i) chk("act", rows[i][15:0], act);
    end
    fclear;
    @(negedge clk_sys_i) warn = 16'hffff;
    @(negedge clk_sys_i) warn = 16'h0;
    rw(0, `DSM_ADDR_SAVED_WARN, 0, 16'h53f7, 0);
    rw(1, `DSM_ADDR_SAVED_WARN, 0, 0, 1);
    rw(1, `DSM_ADDR_ACTION, 16'hffff, 0, 1);
    rw(0, `DSM_ADDR_SAVED_WARN, 0, 16'h53f7, 0);
    fclear;
    rw(0, `DSM_ADDR_SAVED_WARN, 0, 16'h0, 0);
    rw(0, 16'h0100, 0, 16'h0, 1);
    rw(1, `DSM_ADDR_TRACK_CLASS, 16'h1, 0, 0);
    rw(1, `DSM_ADDR_TRACK_CLASS, 16'h0, 0, 1);
    rw(1, `DSM_ADDR_TRACK_CLASS, 16'h4, 0, 1);
    rw(0, `DSM_ADDR_TRACK_CLASS, 0, 16'h1, 0);
    @(negedge clk_sys_i) {te, te_n} = {1'b1, 16'h0abc};
    @(negedge clk_sys_i) te = 1'b0;
    @(negedge clk_sys_i) chk("act", 16'h0842, act);
    rw(1, `DSM_ADDR_STOP_ERR, 16'h0, 0, 1);
    rw(0, `DSM_ADDR_STOP_ERR, 0, 16'h0abc, 0);
    fclear;
    chk("act", 16'h0840, act);
    @(negedge clk_sys_i) {sf, sf_n} = {1'b1, 16'h0123};
    @(negedge clk_sys_i) sf = 1'b0;
    rw(0, `DSM_ADDR_STOP_ERR, 0, 16'h0123, 0);
    // Mid-run reset, then a tracking error at the default class 3
    @(negedge clk_sys_i) rst_i = 1'b1;
    @(negedge clk_sys_i) rst_i = 1'b0;
    chk("cls", 16'h3, {14'h0, cls});
    rw(0, `DSM_ADDR_STOP_ERR, 0, 16'h0, 0);
    @(negedge clk_sys_i) {te, te_n} = {1'b1, 16'h0def};
    @(negedge clk_sys_i) te = 1'b0;
    @(negedge clk_sys_i) chk("act", 16'h0848, act);
    // Warning and fault clear in one cycle: the warning stays saved
    @(negedge clk_sys_i) {fc, warn} = {1'b1, 16'h0001};
    @(negedge clk_sys_i) {fc, warn} = {1'b0, 16'h0000};
    rw(0, `DSM_ADDR_SAVED_WARN, 0, 16'h0001, 0);
    end_sim;
  end
endmodule
